// *** rtl/dtwt_top.sv ***
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`include "dtwt_consts.svh"
module dtwt_top #(
  parameter logic [12:0] PAT_PAIRS = `DT_PAT_PAIRS
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        srst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // trigger pins
  input  wire logic        inputTriggerPin,
  input  wire logic        aoTriggerPin,
  // acquisition pacing
  output logic             aiSampleStrobe,
  output logic      [15:0] aiQueueIndex,
  // converter outputs
  output logic             outputUpdateStrobe,
  output logic      [15:0] aoCh0Code,
  output logic      [15:0] aoCh1Code
);

  dtwt_pkg::dtwt_state_s  q;
  dtwt_pkg::dtwt_state_s  d;
  dtwt_pkg::dtwt_aimode_e aiMode;
  logic        take;
  logic        wr;
  logic        aiEvt;
  logic        aoEvt;
  logic        gated;
  logic        gateOn;
  logic        aiRt;
  logic        aiDlyd;
  logic        goScan;
  logic        aiFin;
  logic        aoFin;
  logic        cmdAiStart;
  logic        cmdAiRst;
  logic        cmdAoStart;
  logic        cmdAoRst;
  logic        cmdSwUpd;
  logic        memWe;
  logic [31:0] rdData;
  logic [31:0] patMem [0:PAT_PAIRS-13'h1];

  // register address match, shared by read and write decode
  function automatic logic at(input logic [11:0] a, input logic [11:0] o);
    return a == o;
  endfunction

  // next-state logic
  always_comb begin
    d = q;
    memWe = 1'b0;
    goScan = 1'b0;
    aiFin = 1'b0;
    aoFin = 1'b0;
    // pin synchronisers; a change counts once stages two and three agree
    d.aiSync = {q.aiSync[1:0], inputTriggerPin};
    d.aoSync = {q.aoSync[1:0], aoTriggerPin};
    if (q.aiSync[1] == q.aiSync[2]) d.aiLvl = q.aiSync[2];
    if (q.aoSync[1] == q.aoSync[2]) d.aoLvl = q.aoSync[2];
    d.aiLvlP = q.aiLvl;
    d.aoLvlP = q.aoLvl;
    aiEvt = (q.aiLvl != q.aiLvlP) && (q.aiLvl != q.aiCfg[`DT_AI_POL]);
    aoEvt = (q.aoLvl != q.aoLvlP) && (q.aoLvl != q.aoCfg[`DT_AO_POL]);
    // 80 MHz timebase tick from the 125 MHz clock by fractional accumulation
    d.tick = 1'b0;
    if (q.tbAcc >= `DT_SYS_MHZ - `DT_TB_MHZ) begin
      d.tbAcc = q.tbAcc - (`DT_SYS_MHZ - `DT_TB_MHZ);
      d.tick = 1'b1;
    end else begin
      d.tbAcc = q.tbAcc + `DT_TB_MHZ;
    end

    // apb: ready one cycle into access, write lands on the ready edge
    take = psel && penable && !q.pready;
    wr = psel && penable && q.pready && pwrite;
    d.pready = take;
    d.pslverr = 1'b0;
    if (take) begin
      d.prdata = 32'h0;
      if (at(paddr, `DT_R_CTRL)) d.prdata = 32'h0;
      else if (at(paddr, `DT_R_STAT)) d.prdata = {28'h0, q.aoDone,
        q.aoSt != dtwt_pkg::AO_IDLE, q.aiDone, q.aiSt != dtwt_pkg::AI_IDLE};
      else if (at(paddr, `DT_R_AICFG)) d.prdata = {27'h0, q.aiCfg};
      else if (at(paddr, `DT_R_AISCANS)) d.prdata = q.aiScans;
      else if (at(paddr, `DT_R_AISMP)) d.prdata = q.aiSmp;
      else if (at(paddr, `DT_R_AIDLY)) d.prdata = q.aiDly;
      else if (at(paddr, `DT_R_AIRETRIG)) d.prdata = q.aiRetrig;
      else if (at(paddr, `DT_R_AISCIVL)) d.prdata = q.aiScanIvl;
      else if (at(paddr, `DT_R_AISMIVL)) d.prdata = q.aiSmpIvl;
      else if (at(paddr, `DT_R_AOCFG)) d.prdata = {24'h0, q.aoCfg};
      else if (at(paddr, `DT_R_AOUI)) d.prdata = q.aoUi;
      else if (at(paddr, `DT_R_AOUC)) d.prdata = q.aoUc;
      else if (at(paddr, `DT_R_AOIC)) d.prdata = q.aoIc;
      else if (at(paddr, `DT_R_AODLY1)) d.prdata = q.aoDly1;
      else if (at(paddr, `DT_R_AODLY2)) d.prdata = q.aoDly2;
      else if (at(paddr, `DT_R_AOTRIG)) d.prdata = q.aoTrigCnt;
      else if (at(paddr, `DT_R_AOSW)) d.prdata = q.aoSwData;
      else if (at(paddr, `DT_R_AODATA)) d.prdata = {19'h0, q.patLen};
      else d.pslverr = 1'b1;
    end
    // register writes
    if (wr) begin
      if (at(paddr, `DT_R_AICFG)) d.aiCfg = pwdata[4:0];
      else if (at(paddr, `DT_R_AISCANS)) d.aiScans = pwdata;
      else if (at(paddr, `DT_R_AISMP)) d.aiSmp = pwdata;
      else if (at(paddr, `DT_R_AIDLY)) d.aiDly = pwdata;
      else if (at(paddr, `DT_R_AIRETRIG)) d.aiRetrig = pwdata;
      else if (at(paddr, `DT_R_AISCIVL)) d.aiScanIvl = pwdata;
      else if (at(paddr, `DT_R_AISMIVL)) d.aiSmpIvl = pwdata;
      else if (at(paddr, `DT_R_AOCFG)) d.aoCfg = pwdata[7:0];
      else if (at(paddr, `DT_R_AOUI)) d.aoUi = pwdata;
      else if (at(paddr, `DT_R_AOUC)) d.aoUc = pwdata;
      else if (at(paddr, `DT_R_AOIC)) d.aoIc = pwdata;
      else if (at(paddr, `DT_R_AODLY1)) d.aoDly1 = pwdata;
      else if (at(paddr, `DT_R_AODLY2)) d.aoDly2 = pwdata;
      else if (at(paddr, `DT_R_AOTRIG)) d.aoTrigCnt = pwdata;
      else if (at(paddr, `DT_R_AOSW)) d.aoSwData = pwdata;
      else if (at(paddr, `DT_R_AODATA) && q.wrPtr != PAT_PAIRS) begin
        memWe = 1'b1;
        d.wrPtr = q.wrPtr + 13'h1;
        d.patLen = q.wrPtr + 13'h1;
      end
    end
    cmdAiStart = wr && at(paddr, `DT_R_CTRL) && pwdata[`DT_C_AISTART];
    cmdAiRst = wr && at(paddr, `DT_R_CTRL) && pwdata[`DT_C_AIRST];
    cmdAoStart = wr && at(paddr, `DT_R_CTRL) && pwdata[`DT_C_AOSTART];
    cmdAoRst = wr && at(paddr, `DT_R_CTRL) && pwdata[`DT_C_AORST];
    cmdSwUpd = wr && at(paddr, `DT_R_CTRL) && pwdata[`DT_C_SWUPD];
    if (wr && at(paddr, `DT_R_CTRL) && pwdata[`DT_C_PATCLR]) begin
      d.wrPtr = 13'h0;
      d.patLen = 13'h0;
    end

    // acquisition sequencer
    aiMode = dtwt_pkg::dtwt_aimode_e'(q.aiCfg[2:0]);
    gated = aiMode == dtwt_pkg::AI_GATED;
    gateOn = q.aiLvl == q.aiCfg[`DT_AI_GLVL];
    aiRt = aiMode == dtwt_pkg::AI_POST_RT || aiMode == dtwt_pkg::AI_DELAY_RT;
    aiDlyd = aiMode == dtwt_pkg::AI_DELAY || aiMode == dtwt_pkg::AI_DELAY_RT;
    d.aiStrobe = 1'b0;
    case (q.aiSt)
      dtwt_pkg::AI_ARM: begin
        if (gated) begin
          if (gateOn) goScan = 1'b1;
        end else if (aiEvt) begin
          if (aiDlyd && q.aiDly != 32'h0) begin
            d.dlyCnt = q.aiDly;
            d.aiSt = dtwt_pkg::AI_WAIT;
          end else begin
            goScan = 1'b1;
          end
        end
      end
      dtwt_pkg::AI_WAIT: begin
        if (q.tick) begin
          d.dlyCnt = q.dlyCnt - 32'h1;
          if (q.dlyCnt == 32'h1) goScan = 1'b1;
        end
      end
      dtwt_pkg::AI_ACQ: begin
        // triggers are not looked at here, so retriggers mid-burst are lost
        if (q.tick) begin
          if (q.smpTmr != 32'h0) d.smpTmr = q.smpTmr - 32'h1;
          if (q.scanTmr != 32'h0) d.scanTmr = q.scanTmr - 32'h1;
          if (q.smpTmr == 32'h1 && q.smpLeft != 32'h0) begin
            d.aiStrobe = 1'b1;
            d.smpLeft = q.smpLeft - 32'h1;
            d.qIdx = q.qIdx + 16'h1;
            d.smpTmr = q.aiSmpIvl;
          end
          if (q.scanTmr == 32'h1) begin
            if (q.scansLeft == 32'h1) begin
              if (aiRt && q.retrigLeft > 32'h1) begin
                d.retrigLeft = q.retrigLeft - 32'h1;
                d.scansLeft = q.aiScans;
                d.aiSt = dtwt_pkg::AI_ARM;
              end else begin
                d.aiSt = dtwt_pkg::AI_IDLE;
                aiFin = 1'b1;
              end
            end else begin
              d.scansLeft = q.scansLeft - 32'h1;
              if (!gated || gateOn) goScan = 1'b1;
              else d.aiSt = dtwt_pkg::AI_ARM;
            end
          end
        end
      end
      default: ;
    endcase
    // scan start: first sample at once, queue restarts at its head
    if (goScan) begin
      d.aiSt = dtwt_pkg::AI_ACQ;
      d.aiStrobe = 1'b1;
      d.smpLeft = q.aiSmp - 32'h1;
      d.qIdx = 16'h0;
      d.smpTmr = q.aiSmpIvl;
      d.scanTmr = q.aiScanIvl;
    end
    if (cmdAiStart || cmdAiRst) begin
      d.aiSt = cmdAiStart ? dtwt_pkg::AI_ARM : dtwt_pkg::AI_IDLE;
      d.scansLeft = q.aiScans;
      d.retrigLeft = q.aiRetrig;
      d.dlyCnt = q.aiDly;
      d.qIdx = 16'h0;
    end
    d.aiDone = aiFin || (q.aiDone && !cmdAiStart);

    // waveform sequencer
    d.aoStrobe = 1'b0;
    case (q.aoSt)
      dtwt_pkg::AO_IDLE: begin
        if (cmdSwUpd && !q.aoCfg[`DT_AO_WAVE]) begin
          d.aoStrobe = 1'b1;
          if (q.aoCfg[`DT_AO_CH0EN]) d.ch0 = q.aoSwData[15:0];
          if (q.aoCfg[`DT_AO_CH1EN]) d.ch1 = q.aoSwData[31:16];
        end
      end
      dtwt_pkg::AO_ARM: begin
        // software source fires as soon as the sequencer is armed
        if (!q.aoCfg[`DT_AO_EXT] || aoEvt) begin
          d.trigsLeft = q.trigsLeft - 32'h1;
          d.ucLeft = q.aoUc;
          d.icLeft = q.aoIc;
          d.uiTmr = q.aoUi;
          if (q.aoCfg[`DT_AO_DELAY] && q.aoDly1 != 32'h0) begin
            d.aoDlyCnt = q.aoDly1;
            d.aoSt = dtwt_pkg::AO_DLY;
          end else begin
            d.aoSt = dtwt_pkg::AO_RUN;
          end
        end
      end
      dtwt_pkg::AO_DLY: begin
        if (q.tick) begin
          d.aoDlyCnt = q.aoDlyCnt - 32'h1;
          if (q.aoDlyCnt == 32'h1) d.aoSt = dtwt_pkg::AO_RUN;
        end
      end
      dtwt_pkg::AO_RUN: begin
        if (q.tick) begin
          d.uiTmr = q.uiTmr - 32'h1;
          if (q.uiTmr == 32'h1) begin
            d.aoStrobe = 1'b1;
            d.uiTmr = q.aoUi;
            d.ucLeft = q.ucLeft - 32'h1;
            if (q.aoCfg[`DT_AO_CH0EN]) d.ch0 = rdData[15:0];
            if (q.aoCfg[`DT_AO_CH1EN]) d.ch1 = rdData[31:16];
            // pointer survives period ends so a short count walks onward
            if (q.rdPtr + 13'h1 >= q.patLen) d.rdPtr = 13'h0;
            else d.rdPtr = q.rdPtr + 13'h1;
            if (q.ucLeft == 32'h1) begin
              d.ucLeft = q.aoUc;
              if (q.aoCfg[`DT_AO_ITER] && (q.aoIc == 32'h0 || q.icLeft > 32'h1)) begin
                d.icLeft = q.icLeft - 32'h1;
                if (q.aoDly2 != 32'h0) begin
                  d.aoDlyCnt = q.aoDly2;
                  d.aoSt = dtwt_pkg::AO_DLY;
                end
              end else if (q.trigsLeft != 32'h0) begin
                d.aoSt = dtwt_pkg::AO_ARM;
              end else begin
                d.aoSt = dtwt_pkg::AO_IDLE;
                aoFin = 1'b1;
              end
            end
          end
        end
      end
      default: ;
    endcase
    if (cmdAoStart || cmdAoRst) begin
      d.aoSt = (cmdAoStart && q.aoCfg[`DT_AO_WAVE]) ? dtwt_pkg::AO_ARM : dtwt_pkg::AO_IDLE;
      d.trigsLeft = q.aoCfg[`DT_AO_RETRIG] ? q.aoTrigCnt : 32'h1;
      d.ucLeft = q.aoUc;
      d.icLeft = q.aoIc;
      d.uiTmr = q.aoUi;
      d.aoDlyCnt = q.aoDly1;
      d.rdPtr = 13'h0;
    end
    d.aoDone = aoFin || (q.aoDone && !cmdAoStart);
  end

  // state register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // pattern store, one word holds channel 0 low and channel 1 high
  always_ff @(posedge clk_sys) begin
    if (memWe) begin
      patMem[q.wrPtr] <= pwdata;
    end
    rdData <= patMem[q.rdPtr];
  end

  // outputs straight from the state register
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign aiSampleStrobe = q.aiStrobe;
  assign aiQueueIndex = q.qIdx;
  assign outputUpdateStrobe = q.aoStrobe;
  assign aoCh0Code = q.ch0;
  assign aoCh1Code = q.ch1;

  // checks on sequencing
  AST_AI_EDGE: assert property (
    @(posedge clk_sys) disable iff (srst)
    aiEvt |-> q.aiLvl != $past(q.aiLvl) && q.aiLvl == $past(q.aiSync[2])
      && q.aiLvl == !q.aiCfg[`DT_AI_POL])
    else $error("trigger event without selected edge");
  AST_AI_DLY: assert property (
    @(posedge clk_sys) disable iff (srst)
    (q.aiSt == dtwt_pkg::AI_WAIT && q.tick && !wr) |=> q.dlyCnt == $past(q.dlyCnt) - 32'h1)
    else $error("delay count did not step on timebase tick");
  AST_AI_IGN: assert property (
    @(posedge clk_sys) disable iff (srst)
    (q.aiSt == dtwt_pkg::AI_ACQ && aiEvt && !q.tick && !wr)
      |=> $stable(q.retrigLeft) && q.aiSt == dtwt_pkg::AI_ACQ)
    else $error("trigger accepted during scan burst");
  AST_AI_GATE: assert property (
    @(posedge clk_sys) disable iff (srst)
    (gated && !gateOn && q.aiSt == dtwt_pkg::AI_ARM) |=> !q.aiStrobe)
    else $error("sample taken while gate inactive");
  AST_AI_LAST: assert property (
    @(posedge clk_sys) disable iff (srst)
    $rose(q.aiDone) |-> $past(q.scansLeft) == 32'h1 && q.aiSt == dtwt_pkg::AI_IDLE)
    else $error("acquisition done before last scan");
  AST_SW_UPD: assert property (
    @(posedge clk_sys) disable iff (srst)
    (cmdSwUpd && !q.aoCfg[`DT_AO_WAVE] && q.aoSt == dtwt_pkg::AO_IDLE)
      |=> q.aoStrobe ##1 !q.aoStrobe)
    else $error("software update not a single strobe");
  AST_AO_TB: assert property (
    @(posedge clk_sys) disable iff (srst)
    (q.aoStrobe && $past(q.aoSt) == dtwt_pkg::AO_RUN) |-> $past(q.tick))
    else $error("waveform update off the timebase");
  AST_AO_TRIG: assert property (
    @(posedge clk_sys) disable iff (srst)
    (q.aoSt == dtwt_pkg::AO_ARM) |-> q.trigsLeft != 32'h0)
    else $error("armed with no triggers left");
  AST_AO_DLY2: assert property (
    @(posedge clk_sys) disable iff (srst)
    (q.aoSt == dtwt_pkg::AO_DLY && $past(q.aoSt) == dtwt_pkg::AO_RUN) |-> q.aoCfg[`DT_AO_ITER])
    else $error("iteration delay outside iterative mode");
  AST_RELOAD: assert property (
    @(posedge clk_sys) disable iff (srst)
    cmdAiStart |=> q.scansLeft == $past(q.aiScans) && q.aiSt == dtwt_pkg::AI_ARM)
    else $error("start did not reload scan count");

  // idle sequencers stay put until a start, queue steps one place per sample
  AST_AI_REST: assert property (
    @(posedge clk_sys) disable iff (srst)
    (q.aiSt == dtwt_pkg::AI_IDLE && !cmdAiStart)
      |=> q.aiSt == dtwt_pkg::AI_IDLE)
    else $error("acquisition left idle without a start");
  AST_AO_REST: assert property (
    @(posedge clk_sys) disable iff (srst)
    (q.aoSt == dtwt_pkg::AO_IDLE && !cmdAoStart)
      |=> q.aoSt == dtwt_pkg::AO_IDLE)
    else $error("waveform left idle without a start");
  AST_AI_QSTEP: assert property (
    @(posedge clk_sys) disable iff (srst)
    (q.aiStrobe && q.qIdx != 16'h0)
      |-> q.qIdx == $past(q.qIdx) + 16'h1)
    else $error("queue index skipped a position");

endmodule // dtwt_top

// *** rtl/dtwt_consts.svh ***
`ifndef DTWT_CONSTS_SVH
`define DTWT_CONSTS_SVH
// Operation
// - raise input trigger on selected edge of trigger pin, polarity programmable
// - sequencer offers post, delayed, gated, post-retrigger, delayed-retrigger modes
// - post mode takes programmed scans of programmed samples each, then stops
// - delayed mode counts delay down per timebase edge, starts at zero
// - input delay counter is 32 bits, clocked by 80 MHz timebase
// - retrigger modes ignore triggers while previous scans still run
// - retrigger modes repeat scan burst per trigger until retrigger count reached
// - gated mode scans only while gate active, holds otherwise, resumes after
// - gated total scans equal programmed count, pausing on scan boundaries
// - output codes are signed 16-bit two's complement
// - software update mode does one update per software command
// - waveform patterns live in a 10k-sample buffer
// - waveform words are consumed channel 0 then channel 1
// - both channels share one mode, each can be disabled
// - each waveform update is paced by the 80 MHz timebase
// - six 32-bit output counters: interval, count, iterations, delays, triggers
// - short update count walks pattern onward across periods
// - waveform waits initial delay after trigger before starting
// - inter-iteration delay applies only in iterative mode
// - retrigger output accepts no more triggers than programmed count
// - software trigger fires at start; source is software or external pin
// - scan interval, sample interval, scans and samples are 32-bit counts
// - samples follow queue order, repeated once per scan
`define DT_SYS_MHZ    8'h7D
`define DT_TB_MHZ     8'h50
`define DT_PAT_PAIRS  13'h1400
`define DT_R_CTRL     12'h000
`define DT_R_STAT     12'h004
`define DT_R_AICFG    12'h008
`define DT_R_AISCANS  12'h00C
`define DT_R_AISMP    12'h010
`define DT_R_AIDLY    12'h014
`define DT_R_AIRETRIG 12'h018
`define DT_R_AISCIVL  12'h01C
`define DT_R_AISMIVL  12'h020
`define DT_R_AOCFG    12'h024
`define DT_R_AOUI     12'h028
`define DT_R_AOUC     12'h02C
`define DT_R_AOIC     12'h030
`define DT_R_AODLY1   12'h034
`define DT_R_AODLY2   12'h038
`define DT_R_AOTRIG   12'h03C
`define DT_R_AOSW     12'h040
`define DT_R_AODATA   12'h044
`define DT_C_AISTART  0
`define DT_C_AIRST    1
`define DT_C_AOSTART  2
`define DT_C_AORST    3
`define DT_C_SWUPD    4
`define DT_C_PATCLR   5
`define DT_AI_POL     3
`define DT_AI_GLVL    4
`define DT_AO_WAVE    0
`define DT_AO_EXT     1
`define DT_AO_DELAY   2
`define DT_AO_RETRIG  3
`define DT_AO_ITER    4
`define DT_AO_CH0EN   5
`define DT_AO_CH1EN   6
`define DT_AO_POL     7
`endif

// *** rtl/dtwt_pkg.sv ***
package dtwt_pkg;
  typedef enum logic [2:0] {AI_POST, AI_DELAY, AI_GATED, AI_POST_RT, AI_DELAY_RT} dtwt_aimode_e;
  typedef enum logic [1:0] {AI_IDLE, AI_ARM, AI_WAIT, AI_ACQ} dtwt_aist_e;
  typedef enum logic [1:0] {AO_IDLE, AO_ARM, AO_DLY, AO_RUN} dtwt_aost_e;
  typedef struct packed {
    logic [2:0]  aiSync;
    logic [2:0]  aoSync;
    logic        aiLvl;
    logic        aiLvlP;
    logic        aoLvl;
    logic        aoLvlP;
    logic [7:0]  tbAcc;
    logic        tick;
    logic [4:0]  aiCfg;
    logic [31:0] aiScans;
    logic [31:0] aiSmp;
    logic [31:0] aiDly;
    logic [31:0] aiRetrig;
    logic [31:0] aiScanIvl;
    logic [31:0] aiSmpIvl;
    logic [7:0]  aoCfg;
    logic [31:0] aoUi;
    logic [31:0] aoUc;
    logic [31:0] aoIc;
    logic [31:0] aoDly1;
    logic [31:0] aoDly2;
    logic [31:0] aoTrigCnt;
    logic [31:0] aoSwData;
    logic [12:0] wrPtr;
    logic [12:0] patLen;
    dtwt_aist_e  aiSt;
    logic [31:0] scansLeft;
    logic [31:0] smpLeft;
    logic [31:0] smpTmr;
    logic [31:0] scanTmr;
    logic [31:0] dlyCnt;
    logic [31:0] retrigLeft;
    logic [15:0] qIdx;
    logic        aiDone;
    logic        aiStrobe;
    dtwt_aost_e  aoSt;
    logic [12:0] rdPtr;
    logic [31:0] uiTmr;
    logic [31:0] ucLeft;
    logic [31:0] icLeft;
    logic [31:0] aoDlyCnt;
    logic [31:0] trigsLeft;
    logic        aoDone;
    logic        aoStrobe;
    logic [15:0] ch0;
    logic [15:0] ch1;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } dtwt_state_s;
endpackage

// *** sim/dtwt_far_side.sv ***
`timescale 1ns/1ns
// far side: both trigger sources and the two converters
module dtwt_far_side (
  // clock
  input  wire logic        clk_sys,
  // converter side
  input  wire logic        outputUpdateStrobe,
  input  wire logic [15:0] aoCh0Code,
  input  wire logic [15:0] aoCh1Code,
  // trigger pins
  output logic             inputTriggerPin,
  output logic             aoTriggerPin
);
  logic [31:0] codeQ[$];
  // pins idle low until told otherwise
  initial begin
    inputTriggerPin = 1'b0;
    aoTriggerPin    = 1'b0;
  end
  // active level for four clocks, well above the minimum pulse width
  task automatic pulse(input logic onAo, input logic act);
    repeat (4) begin
      @(posedge clk_sys);
      if (onAo) aoTriggerPin <= act;
      else inputTriggerPin <= act;
    end
    @(posedge clk_sys);
    if (onAo) aoTriggerPin <= ~act;
    else inputTriggerPin <= ~act;
  endtask
  // static level, used as idle level or as gate
  task automatic level(input logic v);
    @(posedge clk_sys);
    inputTriggerPin <= v;
  endtask
  // converters latch both words per update, channel 0 in the low half
  always @(posedge clk_sys) begin
    if (outputUpdateStrobe === 1'b1) codeQ.push_back({aoCh1Code, aoCh0Code});
  end
endmodule // dtwt_far_side

// *** sim/tb_daq_trigger_waveform_timing.sv ***
`timescale 1ns/1ns
`include "dtwt_consts.svh"
module tb_daq_trigger_waveform_timing;
  // stimulus and observation
  logic        clk_sys = 1'b0;
  logic        srst    = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h00000000;
  logic [31:0] prdata;
  logic        pready, pslverr, inputTriggerPin, aoTriggerPin;
  logic        aiSampleStrobe, outputUpdateStrobe;
  logic [15:0] aiQueueIndex, aoCh0Code, aoCh1Code;
  logic [31:0] seed = 32'h0000826A;
  logic [31:0] rdv, pat[5];
  logic        err;
  logic [15:0] idxQ[$];
  int          n_fail, checks, cyc, nAi, firstAi, t0, n, sc, sm;
  // 125 MHz clock
  always #4 clk_sys = ~clk_sys;
  dtwt_top uut (
    .clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .inputTriggerPin(inputTriggerPin), .aoTriggerPin(aoTriggerPin),
    .aiSampleStrobe(aiSampleStrobe), .aiQueueIndex(aiQueueIndex),
    .outputUpdateStrobe(outputUpdateStrobe), .aoCh0Code(aoCh0Code), .aoCh1Code(aoCh1Code));
  dtwt_far_side far (
    .clk_sys(clk_sys), .outputUpdateStrobe(outputUpdateStrobe), .aoCh0Code(aoCh0Code),
    .aoCh1Code(aoCh1Code), .inputTriggerPin(inputTriggerPin), .aoTriggerPin(aoTriggerPin));
  // repeatable random source
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // expected figures
  function automatic int expCnt(int scans, int smp, int trigs);
    return scans * smp * trigs;
  endfunction
  function automatic int expDly(int ticks);
    return ticks * 125 / 80;
  endfunction
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // poll status until a done bit shows
  task automatic wait_stat(input int b);
    for (int k = 0; k < 1500; k++) begin
      apb(1'b0, `DT_R_STAT, 32'h00000000);
      if (rdv[b] === 1'b1) break;
    end
    check("done flag", rdv[b], 1'b1);
  endtask
  // program the acquisition side and arm it
  task automatic setup_ai(input int cfg, input int s, input int m, input int d, input int r);
    apb(1'b1, `DT_R_AICFG, cfg);
    apb(1'b1, `DT_R_AISCANS, s);
    apb(1'b1, `DT_R_AISMP, m);
    apb(1'b1, `DT_R_AIDLY, d);
    apb(1'b1, `DT_R_AIRETRIG, r);
    apb(1'b1, `DT_R_AISCIVL, m * 4 + 2);
    apb(1'b1, `DT_R_AISMIVL, 4);
    nAi = 0;
    idxQ.delete();
    apb(1'b1, `DT_R_CTRL, 1 << `DT_C_AISTART);
    repeat (20) @(posedge clk_sys);
    check("no trigger no sample", nAi, 0);
  endtask
  // sample monitor and hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (aiSampleStrobe === 1'b1) begin
      if (nAi == 0) firstAi = cyc;
      nAi++;
      idxQ.push_back(aiQueueIndex);
    end
    if (cyc == 40000) begin
      n_fail++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    apb(1'b0, `DT_R_STAT, 32'h00000000);
    check("stat after reset", rdv, 32'h00000000);
    apb(1'b0, 12'hFFC, 32'h00000000);
    check("unmapped error", err, 1'b1);
    $display("test bus done");
    // post mode, both edge polarities, random sizes
    for (int p = 0; p < 2; p++) begin
      sc = 1 + rnd() % 3;
      sm = 1 + rnd() % 4;
      far.level(p[0]);
      setup_ai(p << `DT_AI_POL, sc, sm, 0, 0);
      far.pulse(1'b0, ~p[0]);
      wait_stat(1);
      check("post samples", nAi, expCnt(sc, sm, 1));
      for (int k = 0; k < idxQ.size(); k++) check("queue order", idxQ[k], k % sm);
    end
    far.level(1'b0);
    $display("test post done");
    // delayed mode: 100 ticks before the first sample
    setup_ai(1, 1, 2, 100, 0);
    t0 = cyc;
    far.pulse(1'b0, 1'b1);
    wait_stat(1);
    check("delay low", (firstAi - t0) >= expDly(100), 1'b1);
    check("delay high", (firstAi - t0) <= expDly(100) + 30, 1'b1);
    $display("test delay done");
    // both retrigger modes, extra trigger inside the first burst
    for (int md = 3; md < 5; md++) begin
      setup_ai(md, 2, 2, 10, 2);
      far.pulse(1'b0, 1'b1);
      repeat (10) @(posedge clk_sys);
      far.pulse(1'b0, 1'b1);
      repeat (150) @(posedge clk_sys);
      check("burst ignores trigger", nAi, expCnt(2, 2, 1));
      far.pulse(1'b0, 1'b1);
      wait_stat(1);
      check("retrigger total", nAi, expCnt(2, 2, 2));
    end
    $display("test retrigger done");
    // gated mode, gate active high, held off first
    setup_ai(32'h12, 3, 2, 0, 0);
    repeat (150) @(posedge clk_sys);
    check("gate closed", nAi, 0);
    far.level(1'b1);
    repeat (26) @(posedge clk_sys);
    far.level(1'b0);
    repeat (100) @(posedge clk_sys);
    check("gate pause", nAi, expCnt(2, 2, 1));
    far.level(1'b1);
    wait_stat(1);
    check("gated total", nAi, expCnt(3, 2, 1));
    far.level(1'b0);
    $display("test gated done");
    // software updates, full-scale and plus/minus one corner codes then random
    apb(1'b1, `DT_R_AOCFG, 32'h00000060);
    for (int i = 0; i < 3; i++) begin
      rdv = (i == 0) ? 32'h80007FFF : (i == 1) ? 32'hFFFF0001 : rnd();
      pat[0] = rdv;
      apb(1'b1, `DT_R_AOSW, pat[0]);
      n = far.codeQ.size();
      apb(1'b1, `DT_R_CTRL, 1 << `DT_C_SWUPD);
      repeat (5) @(posedge clk_sys);
      check("one update", far.codeQ.size(), n + 1);
      check("sw codes", far.codeQ[$], pat[0]);
    end
    apb(1'b1, `DT_R_AOCFG, 32'h00000020);
    apb(1'b1, `DT_R_AOSW, 32'h7FFF8000);
    apb(1'b1, `DT_R_CTRL, 1 << `DT_C_SWUPD);
    repeat (5) @(posedge clk_sys);
    check("ch1 disabled", far.codeQ[$], {pat[0][31:16], 16'h8000});
    $display("test software update done");
    // waveform: 5 words, 3 updates per period, 2 iterations
    apb(1'b1, `DT_R_CTRL, 1 << `DT_C_PATCLR);
    for (int k = 0; k < 5; k++) begin
      pat[k] = rnd();
      apb(1'b1, `DT_R_AODATA, pat[k]);
    end
    apb(1'b0, `DT_R_AODATA, 32'h00000000);
    check("pattern length", rdv, 32'h00000005);
    apb(1'b1, `DT_R_AOUI, 80);
    apb(1'b1, `DT_R_AOUC, 3);
    apb(1'b1, `DT_R_AOIC, 2);
    apb(1'b1, `DT_R_AODLY1, 0);
    apb(1'b1, `DT_R_AODLY2, 10);
    apb(1'b1, `DT_R_AOCFG, 32'h00000071);
    sc = far.codeQ.size();
    apb(1'b1, `DT_R_CTRL, 1 << `DT_C_AOSTART);
    wait_stat(3);
    check("update total", far.codeQ.size(), sc + 6);
    for (int j = 0; j < 6; j++) check("wave word", far.codeQ[sc + j], pat[j % 5]);
    $display("test waveform done");
    // external start, retrigger count two, only two triggers accepted
    apb(1'b1, `DT_R_AOCFG, 32'h0000006F);
    apb(1'b1, `DT_R_AOTRIG, 2);
    apb(1'b1, `DT_R_AODLY1, 20);
    apb(1'b1, `DT_R_AOIC, 1);
    apb(1'b1, `DT_R_AOUC, 2);
    sc = far.codeQ.size();
    apb(1'b1, `DT_R_CTRL, 1 << `DT_C_AOSTART);
    repeat (40) @(posedge clk_sys);
    check("waits for pin", far.codeQ.size(), sc);
    far.pulse(1'b1, 1'b1);
    repeat (320) @(posedge clk_sys);
    check("first trigger", far.codeQ.size(), sc + 2);
    far.pulse(1'b1, 1'b1);
    wait_stat(3);
    far.pulse(1'b1, 1'b1);
    repeat (400) @(posedge clk_sys);
    check("trigger count", far.codeQ.size(), sc + 4);
    $display("test external done");
    give_verdict();
  end
endmodule // tb_daq_trigger_waveform_timing
